/* File: hw/channel_output_led_control.v */
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "chan_out_led_regs.vh"
module channel_output_led_control #(
    parameter CH = 4
) (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [CH-1:0] direct_drive_i,
    input wire [CH-1:0] supply_uvlo_i,
    input wire [CH-1:0] line_level_i,
    input wire [CH-1:0] fault_detect_i,
    output reg [CH-1:0] drive_enable_o,
    output reg [CH-1:0] drive_level_o,
    output reg [CH-1:0] status_lamp_o,
    output reg [CH-1:0] fault_lamp_o
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_n_reg;
    // asynchronous assert, two-flop synchronous release
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [CH-1:0] drive_s;
    wire [CH-1:0] uvlo_s;
    wire [CH-1:0] line_s;
    wire [CH-1:0] fault_s;
    // drive and undervoltage pins for the output lanes
    sync2 #(.WIDTH(2 * CH)) u_ctrl_pins (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_reg),
        .d_i({direct_drive_i, supply_uvlo_i}),
        .q_o({drive_s, uvlo_s})
    );
    // sensed line and fault pins for the automatic lamps
    sync2 #(.WIDTH(2 * CH)) u_sense_pins (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_reg),
        .d_i({line_level_i, fault_detect_i}),
        .q_o({line_s, fault_s})
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] dir_level_reg;
    reg [7:0] dir_level_next;
    reg [7:0] lamp_ctrl_reg;
    reg [7:0] lamp_ctrl_next;
    reg [1:0] lamp_cfg_reg;
    reg [1:0] lamp_cfg_next;
    reg [3:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg aw_full_reg;
    reg w_full_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;
    reg aw_full_next;
    reg w_full_next;
    reg [3:0] awaddr_next;
    reg [31:0] wdata_next;
    reg [3:0] wstrb_next;
    reg bvalid_next;
    reg [1:0] bresp_next;
    reg rvalid_next;
    reg [31:0] rdata_next;
    reg [1:0] rresp_next;

    wire [CH-1:0] input_sel = dir_level_reg[`HI_NIBBLE_MSB:`HI_NIBBLE_LSB];
    wire [CH-1:0] level_bits = dir_level_reg[`LO_NIBBLE_MSB:`LO_NIBBLE_LSB];
    wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wire wr_ok = do_write && wstrb_reg[0];
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire rd_take = s_axi_arvalid && s_axi_arready;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // held write address, compared once both halves are in
    wire wr_sel_dir = (awaddr_reg == `OFS_DIR_LEVEL);
    wire wr_sel_lamp = (awaddr_reg == `OFS_LAMP_CTRL);
    wire wr_sel_cfg = (awaddr_reg == `OFS_LAMP_CFG);
    wire wr_addr_hit = wr_sel_dir | wr_sel_lamp | wr_sel_cfg;
    // read address straight off the bus, decoded in the take cycle
    wire rd_sel_dir = (s_axi_araddr == `OFS_DIR_LEVEL);
    wire rd_sel_lamp = (s_axi_araddr == `OFS_LAMP_CTRL);
    wire rd_sel_cfg = (s_axi_araddr == `OFS_LAMP_CFG);
    wire rd_addr_hit = rd_sel_dir | rd_sel_lamp | rd_sel_cfg;

    // ------------------------------------------------------------
    // write channels
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // address and data captured in either order, answered once both held
    always @* begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (aw_take) begin
            aw_full_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (w_take) begin
            w_full_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_addr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write response
    // ------------------------------------------------------------
    // write channel state, cleared by reset
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    // direction/level next value: write, then undervoltage clear
    always @* begin
        dir_level_next = dir_level_reg;
        if (wr_ok && wr_sel_dir)
            dir_level_next = wdata_reg[7:0];
        // undervoltage wins over a write in the same cycle
        dir_level_next[`LO_NIBBLE_MSB:`LO_NIBBLE_LSB] =
            dir_level_next[`LO_NIBBLE_MSB:`LO_NIBBLE_LSB] & ~uvlo_s;
    end

    // lamp control next value, software bits only
    always @* begin
        lamp_ctrl_next = lamp_ctrl_reg;
        if (wr_ok && wr_sel_lamp)
            lamp_ctrl_next = wdata_reg[7:0];
    end

    // lamp override next value: bit 1 status, bit 0 fault
    always @* begin
        lamp_cfg_next = lamp_cfg_reg;
        if (wr_ok && wr_sel_cfg)
            lamp_cfg_next = wdata_reg[1:0];
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    // direction/level storage, cleared by reset
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            dir_level_reg <= `REG_RESET;
        end else begin
            dir_level_reg <= dir_level_next;
        end
    end

    // lamp control storage, cleared by reset
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lamp_ctrl_reg <= `REG_RESET;
        end else begin
            lamp_ctrl_reg <= lamp_ctrl_next;
        end
    end

    // lamp override storage, cleared by reset
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lamp_cfg_reg <= `CFG_RESET;
        end else begin
            lamp_cfg_reg <= lamp_cfg_next;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // read next state: data latched in the take cycle, held until taken
    always @* begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rd_take) begin
            rvalid_next = 1'b1;
            rresp_next = rd_addr_hit ? `RESP_OKAY : `RESP_SLVERR;
            rdata_next = 32'h0;
            if (rd_sel_dir)
                rdata_next = {24'h0, dir_level_reg};
            if (rd_sel_lamp)
                rdata_next = {24'h0, lamp_ctrl_reg};
            if (rd_sel_cfg)
                rdata_next = {30'h0, lamp_cfg_reg};
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // one read at a time, data one cycle after address taken
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ------------------------------------------------------------
    // channel outputs
    // ------------------------------------------------------------
    wire [CH-1:0] enable_next;
    wire [CH-1:0] level_next;
    genvar ch;
    // one lane per channel
    generate
        for (ch = 0; ch < CH; ch = ch + 1) begin : g_lane
            // output mode: driver on, level is pin OR register bit
            assign enable_next[ch] = ~input_sel[ch];
            // input mode: level bit and pin ignored, driver stays off
            assign level_next[ch] = ~input_sel[ch] & (drive_s[ch] | level_bits[ch]);
        end
    endgenerate

    // ------------------------------------------------------------
    // lamps
    // ------------------------------------------------------------
    // automatic sources: line level for status, fault or undervoltage for fault
    wire [CH-1:0] status_auto = line_s;
    wire [CH-1:0] fault_auto = fault_s | uvlo_s;
    wire [CH-1:0] status_sel;
    wire [CH-1:0] fault_sel;
    lamp_mux #(.CH(CH)) u_status_mux (
        .override_i(lamp_cfg_reg[`CFG_STATUS_OVR]),
        .sw_bits_i(lamp_ctrl_reg[`HI_NIBBLE_MSB:`HI_NIBBLE_LSB]),
        .auto_bits_i(status_auto),
        .lamp_o(status_sel)
    );
    lamp_mux #(.CH(CH)) u_fault_mux (
        .override_i(lamp_cfg_reg[`CFG_FAULT_OVR]),
        .sw_bits_i(lamp_ctrl_reg[`LO_NIBBLE_MSB:`LO_NIBBLE_LSB]),
        .auto_bits_i(fault_auto),
        .lamp_o(fault_sel)
    );

    // registered lane outputs
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            drive_enable_o <= {CH{1'b0}};
            drive_level_o <= {CH{1'b0}};
        end else begin
            drive_enable_o <= enable_next;
            drive_level_o <= level_next;
        end
    end

    // registered lamp outputs
    always @(posedge ref_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            status_lamp_o <= {CH{1'b0}};
            fault_lamp_o <= {CH{1'b0}};
        end else begin
            status_lamp_o <= status_sel;
            fault_lamp_o <= fault_sel;
        end
    end
endmodule

/* File: hw/chan_out_led_regs.vh */
// How it works
// - direction bits 7..4: 0 output, 1 input
// - level bit 1 drives high, 0 low
// - output state is pin OR level bit
// - input mode ignores level bit
// - channel undervoltage clears its level bit
// - status lamp bits 7..4 drive lamps
// - override 0 internal state, 1 register bits
// - fault lamp bits 3..0 drive lamps
// - fault override 1 register, 0 detected faults
`ifndef CHAN_OUT_LED_REGS_VH
`define CHAN_OUT_LED_REGS_VH
`define OFS_DIR_LEVEL 4'h0
`define OFS_LAMP_CTRL 4'h4
`define OFS_LAMP_CFG 4'h8
`define REG_RESET 8'h00
`define CFG_RESET 2'h0
`define HI_NIBBLE_MSB 7
`define HI_NIBBLE_LSB 4
`define LO_NIBBLE_MSB 3
`define LO_NIBBLE_LSB 0
`define CFG_STATUS_OVR 1
`define CFG_FAULT_OVR 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: hw/sync2.v */
`timescale 1ns/1ps
module sync2 #(
    parameter WIDTH = 4
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] q_reg;
    // two-stage synchroniser, first stage read only by the second
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= {WIDTH{1'b0}};
            q_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d_i;
            q_reg <= meta_reg;
        end
    end
    assign q_o = q_reg;
endmodule

/* File: hw/lamp_mux.v */
`timescale 1ns/1ps
module lamp_mux #(
    parameter CH = 4
) (
    input wire override_i,
    input wire [CH-1:0] sw_bits_i,
    input wire [CH-1:0] auto_bits_i,
    output wire [CH-1:0] lamp_o
);
    // software bits when override set, device state otherwise
    assign lamp_o = override_i ? sw_bits_i : auto_bits_i;
endmodule

/* File: tb/ctl_monitor.sv */
`timescale 1ns/1ps
`include "chan_out_led_regs.vh"
module ctl_monitor #(
    parameter CH = 4
) (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire [CH-1:0] direct_drive_i,
    input wire [CH-1:0] supply_uvlo_i,
    input wire [CH-1:0] drive_enable_o,
    input wire [CH-1:0] drive_level_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [2:0] up_cnt;
    // cycles since reset release, so pin history is valid
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            up_cnt <= 3'h0;
        else if (up_cnt != 3'h7)
            up_cnt <= up_cnt + 3'h1;
    end
    // --------------------------------------------
    // output lanes and bus
    // --------------------------------------------
    AST_INPUT_IDLE: assert property (
        (drive_level_o & ~drive_enable_o) == '0) else $error("input channel is driven");
    AST_PIN_OR: assert property (
        up_cnt == 3'h7 |-> (drive_enable_o & ~drive_level_o & $past(direct_drive_i, 2)
        & $past(direct_drive_i, 3) & $past(direct_drive_i, 4)) == '0) else $error("held pin not driven");
    AST_UVLO_CLEAR: assert property (
        up_cnt == 3'h7 |-> (drive_level_o & $past(supply_uvlo_i & ~direct_drive_i, 2)
        & $past(supply_uvlo_i & ~direct_drive_i, 3) & $past(supply_uvlo_i & ~direct_drive_i, 4)
        & $past(supply_uvlo_i & ~direct_drive_i, 5)) == '0) else $error("level kept under uvlo");
    AST_B_AFTER_W: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    AST_R_AFTER_AR: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
    AST_R_UPPER: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    AST_AR_BLOCK: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    AST_AW_BLOCK: assert property (
        s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");
endmodule
bind channel_output_led_control ctl_monitor #(.CH(CH)) mon_u (.*);

/* File: tb/field_load_model.sv */
`timescale 1ns/1ps
module field_load_model (
    input wire [3:0] drive_enable_i,
    input wire [3:0] drive_level_i,
    input wire [3:0] ext_level_i,
    output wire [3:0] line_level_o
);
    // a driven line follows its driver, an input line shows the field
    assign line_level_o = (drive_enable_i & drive_level_i) | (~drive_enable_i & ext_level_i);
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "chan_out_led_regs.vh"
module tb_top;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, ext_level = 4'h0;
    logic [3:0] direct_drive_i = 4'h0, supply_uvlo_i = 4'h0, fault_detect_i = 4'h0, u;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [1:0] rs;
    logic [7:0] r0, r1;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] line_level_i, drive_enable_o, drive_level_o, status_lamp_o, fault_lamp_o;
    int num_errors = 0, total_checks = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    channel_output_led_control dut_u (.*);
    field_load_model load_u (.drive_enable_i(drive_enable_o), .drive_level_i(drive_level_o),
        .ext_level_i(ext_level), .line_level_o(line_level_i));
    // ---------------------------------
    // expectation, compare and bus tasks
    // ---------------------------------
    function automatic logic [3:0] exp_lvl(input logic [7:0] r, input logic [3:0] p);
        return 4'(~r[7:4]) & (r[3:0] | p);
    endfunction
    task automatic complete_run();
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tr, te;
        @(posedge ref_clk_i);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        repeat (40) begin
            @(negedge ref_clk_i);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tr = s_axi_arvalid & s_axi_arready;
            te = wr ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge ref_clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            if (te) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        num_errors++;
        complete_run();
    endtask
    // main sequence: reset map, lanes, undervoltage, lamps
    initial begin
        void'($urandom(8));
        repeat (6) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        for (int a = 0; a < 16; a += 4) begin
            axi(1'b0, a[3:0], 32'h0);
            check_val(rd, 32'h0);
            check_val(rs, a == 12 ? `RESP_SLVERR : `RESP_OKAY);
        end
        axi(1'b1, 4'hc, 32'hff);
        check_val(rs, `RESP_SLVERR);
        s_axi_wstrb <= 4'he;
        axi(1'b1, `OFS_DIR_LEVEL, 32'hff);
        check_val(rs, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi(1'b0, `OFS_DIR_LEVEL, 32'h0);
        check_val(rd, 32'h0);
        for (int i = 0; i < 24; i++) begin
            r0 = i < 2 ? (i == 0 ? 8'h0f : 8'hf0) : 8'($urandom);
            axi(1'b1, `OFS_DIR_LEVEL, {24'h0, r0});
            direct_drive_i <= i < 4 ? 4'h0 : 4'($urandom);
            repeat (6) @(posedge ref_clk_i);
            check_val(drive_enable_o, 4'(~r0[7:4]));
            check_val(drive_level_o, exp_lvl(r0, direct_drive_i));
            axi(1'b0, `OFS_DIR_LEVEL, 32'h0);
            check_val(rd, {24'h0, r0});
        end
        direct_drive_i <= 4'h0;
        axi(1'b1, `OFS_DIR_LEVEL, 32'h0f);
        u = 4'($urandom) | 4'h1;
        supply_uvlo_i <= u;
        repeat (6) @(posedge ref_clk_i);
        check_val(drive_level_o, 4'(~u));
        supply_uvlo_i <= 4'h0;
        axi(1'b0, `OFS_DIR_LEVEL, 32'h0);
        check_val(rd, {28'h0, 4'(~u)});
        for (int i = 0; i < 16; i++) begin
            r0 = 8'($urandom);
            r1 = 8'($urandom);
            fault_detect_i <= 4'($urandom);
            ext_level <= 4'($urandom);
            axi(1'b1, `OFS_DIR_LEVEL, {24'h0, r0});
            axi(1'b1, `OFS_LAMP_CFG, {30'h0, i[1:0]});
            axi(1'b1, `OFS_LAMP_CTRL, {24'h0, r1});
            repeat (6) @(posedge ref_clk_i);
            check_val(status_lamp_o, i[1] ? r1[7:4] : exp_lvl(r0, 4'h0) | (r0[7:4] & ext_level));
            check_val(fault_lamp_o, i[0] ? r1[3:0] : fault_detect_i);
            axi(1'b0, `OFS_LAMP_CTRL, 32'h0);
            check_val(rd, {24'h0, r1});
        end
        complete_run();
    end
endmodule
